// [svm_pkg.sv]
// Purpose: shared constants and types for the supply monitor control block
// Assumes: 16-bit register reached over a plain strobe port
// Notes: all offsets and fields live here, and the control word reset values
package smc_pkg;
   // register map
   localparam logic [7:0] SMC_ADDR_CTRL = 8'h0C;
   localparam logic [7:0] SMC_ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] SMC_ADDR_IRQ_MASK = 8'h14;
   // control register layout
   localparam logic [15:0] SMC_CTRL_RESET = 16'h0700;
   localparam int SMC_BIT_EN = 0;
   localparam int SMC_BIT_RDY = 1;
   localparam int SMC_BIT_IE = 2;
   localparam int SMC_BIT_FLAG = 3;
   localparam int SMC_BIT_STOP = 4;
   localparam int SMC_TH_LO = 8;
   localparam int SMC_TH_HI = 11;
   localparam logic [3:0] SMC_TH_RESET = 4'h7;
   // event status bits: low supply, ready rise
   localparam int SMC_EV_LOW = 0;
   localparam int SMC_EV_RDY = 1;
   localparam int SMC_EV_W = 2;
   // ready settling time, ns, and its cycle count at 100 MHz
   localparam int SMC_CLK_NS = 10;
   localparam int SMC_SETTLE_NS = 1000;
   localparam int SMC_SETTLE_CYC = (SMC_SETTLE_NS + SMC_CLK_NS - 1) / SMC_CLK_NS;
   // register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } smc_bus_req_t;
   // analog monitor controls
   typedef struct packed {
      logic on;
      logic [3:0] thresh;
   } smc_ana_t;
   typedef enum logic [2:0] {
      SMC_OFF = 3'h1,
      SMC_SETTLE = 3'h2,
      SMC_READY = 3'h4
   } smc_state_t;
endpackage

// [svm_ctrl.sv]
// Purpose: control/status register and sequencing for a supply voltage monitor
// Assumes: comparator below-threshold input is asynchronous; stop request is synchronous
// Notes: a ready-settling delay is modelled with a counter parameter
// Notes: event status and mask words share the register port with the control word
// Notes on behaviour
// R01: control register resets to 0700h always
// R02: bit 0 switches monitoring on or off
// R03: ready bit is hardware only, writes ignored
// R04: ready clears when disabled or stopping unsupported
// R05: interrupt enable gates low-supply interrupt request; here it gates o_cpu_irq only, o_irq takes the low event through the mask
// R06: flag sets when supply under threshold
// R07: writing 0 clears; re-sets while still low
// R08: writing 1 sets flag, interrupts if enabled
// R09: stop enable keeps monitor running in stop
// R10: bits 11:8 pick 2.0V plus n*0.1V
// R11: threshold defaults to code 07h, 2.7V
// R12: threshold writes ignored while monitor enabled
// R13: other bits freely readable and writable
// R14: reserved bits zero; comparator input synchronised
//
// Chosen here: the strobed register port.
module smc_ctrl #(
   // cycles from switch-on until the comparator output can be trusted
   parameter int SETTLE_CYC = smc_pkg::SMC_SETTLE_CYC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // register bus
   input wire smc_pkg::smc_bus_req_t i_bus,
   output logic [15:0] o_rdata,
   // system state and comparator
   input wire logic i_stop_mode,
   input wire logic i_below_thresh,
   // analog control and interrupts
   output smc_pkg::smc_ana_t o_ana,
   output logic o_cpu_irq,
   output logic o_irq
);
   // control fields, one flop per bit so each keeps its own write rule
   logic en_ff; // monitor enable
   logic rdy_ff; // monitor ready, hardware only
   logic ie_ff; // low-supply interrupt enable
   logic flag_ff; // sticky low-supply flag
   logic stop_en_ff; // keep monitoring through stop mode
   logic [3:0] th_ff; // threshold code n
   // comparator synchroniser
   logic below_meta_ff; // first stage, may go metastable
   logic below_ff; // second stage, the only one read by logic
   // sequencer
   smc_pkg::smc_state_t state_ff; // current sequencer state
   smc_pkg::smc_state_t nxt_state; // next sequencer state
   logic [15:0] cnt_ff; // settle cycles counted so far
   // event status and mask
   logic [smc_pkg::SMC_EV_W-1:0] ev_st_ff; // sticky event bits
   logic [smc_pkg::SMC_EV_W-1:0] ev_mask_ff; // event mask
   logic [smc_pkg::SMC_EV_W-1:0] ev_set; // events seen this cycle
   logic [smc_pkg::SMC_EV_W-1:0] ev_clr; // write-one-to-clear pattern
   // decoded accesses
   logic wr_ctrl; // write to the control word
   logic wr_st; // write to the event status word
   logic wr_mask; // write to the event mask word
   logic run; // monitor powered at this moment
   logic low_event; // trusted below-threshold level

   // one place for address decode of writes
   function automatic logic hit(input smc_pkg::smc_bus_req_t b, input logic [7:0] a);
      return b.wr && (b.addr == a);
   endfunction

   // write decode; a write to any other address is dropped
   assign wr_ctrl = hit(i_bus, smc_pkg::SMC_ADDR_CTRL);
   assign wr_st = hit(i_bus, smc_pkg::SMC_ADDR_IRQ_STATUS);
   assign wr_mask = hit(i_bus, smc_pkg::SMC_ADDR_IRQ_MASK);

   // monitor runs when enabled, and in stop only with stop enable
   // R09: stop mode gating
   assign run = en_ff && (!i_stop_mode || stop_en_ff);

   // only a ready monitor gives a trustworthy comparator level; an unsettled
   // comparator can swing either way and would raise false low-supply flags
   assign low_event = run && rdy_ff && below_ff;

   // two-flop synchroniser for the comparator level
   // R14: comparator sync
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         below_meta_ff <= 1'b0;
         below_ff <= 1'b0;
      end else begin
         // first stage is read only by the second
         below_meta_ff <= i_below_thresh;
         below_ff <= below_meta_ff;
      end
   end

   // plain read/write control bits
   // R01: reset value
   // R13: unrestricted bits
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         // reset takes the documented word, bit by bit
         en_ff <= smc_pkg::SMC_CTRL_RESET[smc_pkg::SMC_BIT_EN];
         ie_ff <= smc_pkg::SMC_CTRL_RESET[smc_pkg::SMC_BIT_IE];
         stop_en_ff <= smc_pkg::SMC_CTRL_RESET[smc_pkg::SMC_BIT_STOP];
      end else if (wr_ctrl) begin
         // R02: enable bit
         en_ff <= i_bus.wdata[smc_pkg::SMC_BIT_EN];
         // R05: interrupt enable
         ie_ff <= i_bus.wdata[smc_pkg::SMC_BIT_IE];
         // stop enable is plain storage; the gating happens in run
         stop_en_ff <= i_bus.wdata[smc_pkg::SMC_BIT_STOP];
      end
   end

   // threshold field, frozen while the monitor is enabled; the old enable
   // decides, so one write that switches on and sets a code keeps the code
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         // R11: default code
         th_ff <= smc_pkg::SMC_TH_RESET;
      end else if (wr_ctrl && !en_ff) begin
         // R12: write only while off
         th_ff <= i_bus.wdata[smc_pkg::SMC_TH_HI:smc_pkg::SMC_TH_LO];
      end
   end

   // low-supply flag; hardware set wins over a software clear so that a
   // clear racing a fresh low level can never lose the event
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         flag_ff <= 1'b0;
      end else if (low_event) begin
         // R06: hardware set
         // R07: re-set while still low
         flag_ff <= 1'b1;
      end else if (wr_ctrl) begin
         // R08: software may set or clear
         flag_ff <= i_bus.wdata[smc_pkg::SMC_BIT_FLAG];
      end
   end

   // ready sequencer: settle after enable, drop when monitor stops
   always_comb begin
      // hold by default
      nxt_state = state_ff;
      case (state_ff)
         smc_pkg::SMC_OFF: begin
            // power-up starts the settle count
            if (run) begin
               nxt_state = smc_pkg::SMC_SETTLE;
            end
         end
         smc_pkg::SMC_SETTLE: begin
            // a drop during settling restarts from scratch
            if (!run) begin
               nxt_state = smc_pkg::SMC_OFF;
            end else if (cnt_ff >= 16'(SETTLE_CYC - 1)) begin
               nxt_state = smc_pkg::SMC_READY;
            end
         end
         smc_pkg::SMC_READY: begin
            // disable, or stop without stop enable, leaves ready
            if (!run) begin
               nxt_state = smc_pkg::SMC_OFF;
            end
         end
         default: begin
            // an illegal code recovers to off
            nxt_state = smc_pkg::SMC_OFF;
         end
      endcase
   end

   // state, settle counter and ready bit
   // R03: ready is hardware driven only
   // R04: ready cleared when off or stopped without stop enable
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_ff <= smc_pkg::SMC_OFF;
         cnt_ff <= 16'h0000;
         rdy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         // counter only runs while settling, so it cannot wrap in normal use
         cnt_ff <= (nxt_state == smc_pkg::SMC_SETTLE) ? cnt_ff + 16'h0001 : 16'h0000;
         // no bus path reaches this flop, so writes to bit 1 have no effect
         rdy_ff <= (nxt_state == smc_pkg::SMC_READY);
      end
   end

   // event sources: flag rise and ready rise
   assign ev_set[smc_pkg::SMC_EV_LOW] = low_event && !flag_ff;
   assign ev_set[smc_pkg::SMC_EV_RDY] = (nxt_state == smc_pkg::SMC_READY) && !rdy_ff;
   // write-one-to-clear pattern, zero unless the status word is written
   assign ev_clr = wr_st ? i_bus.wdata[smc_pkg::SMC_EV_W-1:0] : '0;

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ev_st_ff <= '0;
      end else begin
         ev_st_ff <= (ev_st_ff & ~ev_clr) | ev_set;
      end
   end

   // event mask, plain storage
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ev_mask_ff <= '0;
      end else if (wr_mask) begin
         ev_mask_ff <= i_bus.wdata[smc_pkg::SMC_EV_W-1:0];
      end
   end

   // read mux, answer in the next cycle; unmapped reads give zero
   // R14: reserved bits read zero
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= 16'h0000;
      end else if (i_bus.rd) begin
         case (i_bus.addr)
            smc_pkg::SMC_ADDR_CTRL: begin
               // reserved bits 15:12 and 7:5 are tied low
               o_rdata <= {4'h0, th_ff, 3'h0, stop_en_ff, flag_ff, ie_ff, rdy_ff, en_ff};
            end
            smc_pkg::SMC_ADDR_IRQ_STATUS: begin
               o_rdata <= {14'h0000, ev_st_ff};
            end
            smc_pkg::SMC_ADDR_IRQ_MASK: begin
               o_rdata <= {14'h0000, ev_mask_ff};
            end
            default: begin
               // unmapped address
               o_rdata <= 16'h0000;
            end
         endcase
      end else begin
         // data stands for one cycle only, then returns to zero
         o_rdata <= 16'h0000;
      end
   end

   // registered outputs; threshold code n means 2.0V + n*0.1V
   // R10: threshold to analog
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_ana <= '0;
         o_cpu_irq <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         // analog side sees power and code one cycle after the flops
         o_ana.on <= run;
         o_ana.thresh <= th_ff;
         // R05: request only with the enable set
         o_cpu_irq <= flag_ff && ie_ff;
         // any unmasked sticky event keeps the level high
         o_irq <= |(ev_st_ff & ev_mask_ff);
      end
   end

   // checks on the control logic; all run on the system clock and are
   // silenced while reset is held, since every flop is forced then

   // R05: cpu request follows
   a_flag_irq: assert property (@(posedge i_clk) disable iff (!i_rstn) // R05
      (flag_ff && ie_ff) |=> o_cpu_irq)
      else $error("cpu request missing");

   // R05: no request disabled
   a_no_irq_dis: assert property (@(posedge i_clk) disable iff (!i_rstn) // R05
      !ie_ff |=> !o_cpu_irq)
      else $error("cpu request while disabled");

   // R04: ready drops off
   a_rdy_clear: assert property (@(posedge i_clk) disable iff (!i_rstn) // R04
      !run |=> !rdy_ff)
      else $error("ready held while off");

   // R12: threshold frozen on
   a_th_locked: assert property (@(posedge i_clk) disable iff (!i_rstn) // R12
      en_ff |=> $stable(th_ff))
      else $error("threshold changed while on");

   // R10: threshold write lands
   a_th_write: assert property (@(posedge i_clk) disable iff (!i_rstn) // R10
      (wr_ctrl && !en_ff) |=> th_ff == $past(i_bus.wdata[smc_pkg::SMC_TH_HI:smc_pkg::SMC_TH_LO]))
      else $error("threshold not written");

   // R06: hardware flag set
   a_flag_set: assert property (@(posedge i_clk) disable iff (!i_rstn) // R06
      low_event |=> flag_ff)
      else $error("flag not set");

   // R08: software flag set
   a_flag_sw: assert property (@(posedge i_clk) disable iff (!i_rstn) // R08
      (wr_ctrl && i_bus.wdata[smc_pkg::SMC_BIT_FLAG]) |=> flag_ff)
      else $error("flag not set by write");

   // R07: software flag clear
   a_flag_clr: assert property (@(posedge i_clk) disable iff (!i_rstn) // R07
      (wr_ctrl && !i_bus.wdata[smc_pkg::SMC_BIT_FLAG] && !low_event) |=> !flag_ff)
      else $error("flag not cleared by write");

   // R06: low event sticks
   a_ev_sticky: assert property (@(posedge i_clk) disable iff (!i_rstn) // R06
      ev_set[smc_pkg::SMC_EV_LOW] |=> ev_st_ff[smc_pkg::SMC_EV_LOW])
      else $error("low event not recorded");

   // R05: event line follows
   a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rstn) // R05
      (|(ev_st_ff & ev_mask_ff)) |=> o_irq)
      else $error("event interrupt missing");

   // R03: ready after settling
   a_rdy_settle: assert property (@(posedge i_clk) disable iff (!i_rstn) // R03
      $rose(rdy_ff) |-> $past(run, 1) && $past(run, 2))
      else $error("ready rose without settling");

   // R02: enable write lands
   a_en_write: assert property (@(posedge i_clk) disable iff (!i_rstn) // R02
      wr_ctrl |=> en_ff == $past(i_bus.wdata[smc_pkg::SMC_BIT_EN]))
      else $error("enable not written");

   // R09: power follows run
   a_on_follow: assert property (@(posedge i_clk) disable iff (!i_rstn) // R09
      1'b1 |=> o_ana.on == $past(run))
      else $error("analog power not following run");

   // R14: reserved reads zero
   a_resv_zero: assert property (@(posedge i_clk) disable iff (!i_rstn) // R14
      o_rdata[15:12] == 4'h0 && o_rdata[7:5] == 3'h0 || $past(i_bus.addr) != smc_pkg::SMC_ADDR_CTRL)
      else $error("reserved bits nonzero");
endmodule

// [svm_tb.sv]
// Purpose: self-checking bench for the supply monitor control block
// Assumes: settling count cut to 4 cycles; comparator input quiet unless a test drives it
// Notes: random register words from a fixed seed, hand-written corner cases among them
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SETTLE = 4;
   localparam logic [7:0] A_CTRL = smc_pkg::SMC_ADDR_CTRL;
   localparam logic [7:0] A_STAT = smc_pkg::SMC_ADDR_IRQ_STATUS;
   localparam logic [7:0] A_MASK = smc_pkg::SMC_ADDR_IRQ_MASK;
   logic i_clk, i_rstn, i_stop_mode, i_below_thresh, o_cpu_irq, o_irq;
   smc_pkg::smc_bus_req_t i_bus;
   smc_pkg::smc_ana_t o_ana;
   logic [15:0] o_rdata, rd_v, w;
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;
   // device with a short settling count so ready comes quickly
   smc_ctrl #(.SETTLE_CYC(SETTLE)) DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus(i_bus),
      .o_rdata(o_rdata), .i_stop_mode(i_stop_mode), .i_below_thresh(i_below_thresh),
      .o_ana(o_ana), .o_cpu_irq(o_cpu_irq), .o_irq(o_irq));
   // 100 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // hang guard, far above the roughly 130 cycles the tests need
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   // expected control word: reserved zero, ready from hardware, threshold as kept
   function automatic logic [15:0] ctrl_exp(logic [15:0] wv, logic [3:0] th, logic rdy);
      return {4'h0, th, 3'h0, wv[4:2], rdy, wv[0]};
   endfunction
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk);
      i_bus.wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk);
      i_bus.rd <= 1'b0;
      #1 rd_v = o_rdata;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence
   initial begin
      i_rstn = 1'b0;
      i_bus = '0;
      i_stop_mode = 1'b0;
      i_below_thresh = 1'b0;
      void'($urandom(69));
      repeat (4) @(posedge i_clk);
      i_rstn <= 1'b1;
      rd(A_CTRL);
      chk_word("ctrl reset", 16'h0700, rd_v);
      chk_word("thresh reset", 16'h0007, {12'h000, o_ana.thresh});
      $display("test reset done");
      // all ones while off: ready and reserved stay zero, flag set by software
      wr(A_CTRL, 16'hFFFE);
      tick(2);
      chk_bit("cpu irq sw set", 1'b1, o_cpu_irq);
      rd(A_CTRL);
      chk_word("ctrl all ones", 16'h0F1C, rd_v);
      wr(A_CTRL, 16'h0704);
      tick(2);
      chk_bit("cpu irq cleared", 1'b0, o_cpu_irq);
      $display("test software flag done");
      // random words with monitoring off: threshold follows the write
      for (int k = 0; k < 6; k++) begin
         w = 16'($urandom) & 16'hFFFE;
         wr(A_CTRL, w);
         rd(A_CTRL);
         chk_word("ctrl random", ctrl_exp(w, w[11:8], 1'b0), rd_v);
         chk_word("thresh out", {12'h000, w[11:8]}, {12'h000, o_ana.thresh});
      end
      wr(A_CTRL, 16'h0500);
      $display("test random words done");
      // enable: threshold taken with old enable low, later change refused
      wr(A_STAT, 16'h0003);
      wr(A_MASK, 16'h0003);
      tick(2);
      chk_bit("irq idle", 1'b0, o_irq);
      wr(A_CTRL, 16'h0901);
      wr(A_CTRL, 16'h0303);
      tick(SETTLE + 4);
      rd(A_CTRL);
      chk_word("ctrl enabled", 16'h0903, rd_v);
      chk_bit("ana on", 1'b1, o_ana.on);
      chk_bit("irq ready rise", 1'b1, o_irq);
      $display("test enable done");
      // low supply with interrupt off, then clear while still low
      @(posedge i_clk);
      i_below_thresh <= 1'b1;
      tick(6);
      rd(A_CTRL);
      chk_word("flag hw set", 16'h090B, rd_v);
      chk_bit("cpu irq gated", 1'b0, o_cpu_irq);
      wr(A_CTRL, 16'h0905);
      tick(4);
      rd(A_CTRL);
      chk_word("flag re-set", 16'h090F, rd_v);
      chk_bit("cpu irq on", 1'b1, o_cpu_irq);
      @(posedge i_clk);
      i_below_thresh <= 1'b0;
      tick(4);
      wr(A_CTRL, 16'h0901);
      wr(A_MASK, 16'h0000);
      tick(2);
      chk_bit("cpu irq off", 1'b0, o_cpu_irq);
      chk_bit("irq masked", 1'b0, o_irq);
      rd(A_STAT);
      chk_word("status", 16'h0003, rd_v);
      wr(A_STAT, 16'h0003);
      rd(A_STAT);
      chk_word("status clr", 16'h0000, rd_v);
      $display("test low supply done");
      // stop mode without and with the stop enable
      @(posedge i_clk);
      i_stop_mode <= 1'b1;
      tick(3);
      chk_bit("on in stop", 1'b0, o_ana.on);
      rd(A_CTRL);
      chk_word("ready stop", 16'h0901, rd_v);
      @(posedge i_clk);
      i_stop_mode <= 1'b0;
      tick(SETTLE + 4);
      wr(A_CTRL, 16'h0911);
      i_stop_mode <= 1'b1;
      tick(3);
      chk_bit("on kept", 1'b1, o_ana.on);
      rd(A_CTRL);
      chk_word("ready kept", 16'h0913, rd_v);
      @(posedge i_clk);
      i_stop_mode <= 1'b0;
      $display("test stop done");
      // disable drops ready; unmapped place reads zero
      wr(A_CTRL, 16'h0910);
      tick(2);
      chk_bit("ana off", 1'b0, o_ana.on);
      rd(A_CTRL);
      chk_word("ready off", 16'h0910, rd_v);
      rd(8'h20);
      chk_word("unmapped", 16'h0000, rd_v);
      $display("test disable done");
      end_sim();
   end
endmodule
